// [logic/pot_pkg.sv]
// Constants shared by the prescaled overflow timer and its prescaler
// ============================================================
// Notes on behaviour
// R1: Count split into separately reachable high/low bytes
// R2: Plain up counter, no period or compare
// R3: Eight-bit prescaler ahead, 24-bit chain overall
// R4: Internal source is the instruction clock
// R5: Control bit 5 set picks internal clock
// R6: Control bit 6 picks external edge polarity
// R7: Bits 4..1 pick 1:1 to 1:256 prescale
// R8: External input synchronised after the prescaler
// R9: Overflow raises an event for interrupts
// R10: FFFFh wraps to 0000h, sets maskable flag
// R11: Flag clears when this vector is taken
// R12: Byte write blocks own increment, clears prescaler
// R13: Prescaler output sampled for edge detection
// R14: Low byte carry steps high byte together
// R15: Control resets to zero, bit 0 reads zero
package pot_pkg;

    // ============================================================
    // Clock
    localparam int CLK_PERIOD_NS = 20;         // Instruction clock period

    // ============================================================
    // Register indices; byte address is four times the index
    localparam logic [5:0] IDX_CTRL   = 6'h05; // timer_zero_control
    localparam logic [5:0] IDX_CNT_LO = 6'h0B; // count_low_byte
    localparam logic [5:0] IDX_CNT_HI = 6'h0C; // count_high_byte
    localparam logic [5:0] IDX_STAT   = 6'h10; // Sticky event status
    localparam logic [5:0] IDX_MASK   = 6'h11; // Interrupt mask

    // ============================================================
    // Control fields
    localparam int CTRL_EXT_INT_EDGE_SELECT_BIT = 7;        // ext_int_edge_select
    localparam int CTRL_EDGE_BIT   = 6;        // ext_edge_select
    localparam int CTRL_SRC_BIT    = 5;        // count_source_select
    localparam int CTRL_PS_LSB     = 1;        // prescale_select low bit
    localparam int PS_W            = 4;        // prescale_select width
    localparam logic [7:0] CTRL_WMASK = 8'hFE; // Bit 0 unimplemented
    localparam logic [7:0] CTRL_RESET = 8'h00;

    // ============================================================
    // Status and mask fields
    localparam int STAT_OVF_BIT = 0;           // overflow_flag
    localparam logic [7:0] STAT_WMASK = 8'h01;
    localparam logic [7:0] STAT_RESET = 8'h00;
    localparam logic [7:0] MASK_RESET = 8'h00;
    localparam logic [7:0] CNT_RESET  = 8'h00;

endpackage

// [logic/pot_prescaler.sv]
// Eight-bit prescaler with source select and post-prescaler synchroniser
`timescale 1ns/1ns
module pot_prescaler #(
    parameter int PS_BITS = 8                  // Prescaler length
) (
    input  wire logic                    clock,
    input  wire logic                    rst_b,
    input  wire logic                    clear,
    input  wire logic                    src_int,
    input  wire logic                    edge_rise,
    input  wire logic [pot_pkg::PS_W-1:0] ps_code,
    input  wire logic                    ext_count_pin,
    output logic                         step
);
    import pot_pkg::*;

    // ============================================================
    // Ratio decode: codes 1xxx all mean the longest division
    function automatic logic [3:0] ps_shift(input logic [PS_W-1:0] c);
        ps_shift = c[3] ? 4'h8 : {1'b0, c[2:0]};
    endfunction

    logic [PS_BITS-1:0] cnt_reg;               // Prescaler count
    logic               pin_prev_reg;          // Previous corrected pin
    logic               sync1_reg;             // Synchroniser first stage
    logic               sync2_reg;             // Synchroniser second stage
    logic               sync3_reg;             // Edge detect history
    logic               step_reg;              // Counting step out

    wire  [3:0]         shift_w  = ps_shift(ps_code);
    // R6 edge polarity
    wire                pin_pol  = edge_rise ? ext_count_pin : ~ext_count_pin;
    wire                pin_edge = pin_pol & ~pin_prev_reg;
    // R7 ratio mask
    wire [PS_BITS-1:0]  low_mask = ~({PS_BITS{1'b1}} << shift_w);
    wire                int_carry = &(cnt_reg | ~low_mask);
    wire [PS_BITS:0]    taps     = {cnt_reg, pin_pol};
    // At 1:1 the pin itself is the prescaler output
    wire                prescaler_output = taps[shift_w];
    wire                cnt_en   = src_int | pin_edge;

    // ============================================================
    // R3 prescale count
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            cnt_reg <= '0;
        end else if (cnt_en) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    // Pin history; tracks the pin in reset too, so that release
    // cannot fake an edge when the idle level is high
    always_ff @(posedge clock) begin
        pin_prev_reg <= pin_pol;
    end

    // ============================================================
    // R8 sync after prescaler
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            // Load the idle level so release shows no edge
            sync1_reg <= prescaler_output;
            sync2_reg <= prescaler_output;
            sync3_reg <= prescaler_output;
        end else begin
            sync1_reg <= prescaler_output;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    // ============================================================
    // R4 internal source step
    // R13 sampled edge detect
    always_ff @(posedge clock) begin
        if (!rst_b || clear) begin
            step_reg <= 1'b0;
        end else if (src_int) begin
            step_reg <= int_carry;
        end else begin
            step_reg <= sync2_reg & ~sync3_reg;
        end
    end

    assign step = step_reg;

endmodule

// [logic/pot_timer.sv]
// Top of the prescaled overflow timer with its Wishbone register slave
`timescale 1ns/1ns
module pot_timer #(
    parameter int PS_BITS = 8                  // Prescaler length
) (
    input  wire logic        clock,
    input  wire logic        rst_b,
    // Wishbone classic slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Count pin and interrupt side
    input  wire logic        ext_count_pin,
    input  wire logic        irq_vector_taken,
    output logic             irq,
    output logic             ext_int_edge_select
);
    import pot_pkg::*;

    // ============================================================
    // Register state

    logic [7:0]  ctrl_reg;                     // timer_zero_control
    logic [7:0]  ctrl_next;
    logic [7:0]  cnt_lo_reg;                   // count_low_byte
    logic [7:0]  cnt_lo_next;
    logic [7:0]  cnt_hi_reg;                   // count_high_byte
    logic [7:0]  cnt_hi_next;
    logic [7:0]  stat_reg;                     // Sticky events
    logic [7:0]  stat_next;
    logic [7:0]  mask_reg;                     // Interrupt mask
    logic [7:0]  mask_next;
    logic        blk_lo_reg;                   // Low byte write hold-off
    logic        blk_hi_reg;                   // High byte write hold-off
    logic        ack_reg;                      // Bus answer
    logic [31:0] dat_reg;                      // Read data
    logic [31:0] dat_next;
    logic        irq_reg;                      // Interrupt level
    logic        irq_next;
    logic        ext_int_edge_select_reg;                   // Edge select copy out

    // ============================================================
    // Bus decode

    // Live request: cycle and strobe both high, whether or not answered
    wire         req     = wb_cyc_i & wb_stb_i;
    // Writes and read side effects land on the ack edge
    wire         fire    = req & ack_reg;
    wire         wr_fire = fire & wb_we_i & wb_sel_i[0];
    wire         rd_fire = fire & ~wb_we_i;
    wire  [5:0]  idx     = wb_adr_i[7:2];
    wire  [7:0]  wbyte   = wb_dat_i[7:0];

    // Per-register hit
    wire         hit_ctrl = (idx == IDX_CTRL);
    wire         hit_lo   = (idx == IDX_CNT_LO);
    wire         hit_hi   = (idx == IDX_CNT_HI);
    wire         hit_stat = (idx == IDX_STAT);
    wire         hit_mask = (idx == IDX_MASK);

    // Write strobes per register
    wire         wr_ctrl = wr_fire & hit_ctrl;
    wire         wr_lo   = wr_fire & hit_lo;
    wire         wr_hi   = wr_fire & hit_hi;
    wire         wr_mask = wr_fire & hit_mask;
    // Status is read-to-clear; writes to it are ignored
    wire         rd_stat = rd_fire & hit_stat;

    // ============================================================
    // Control fields

    // R5 source select
    wire         src_int   = ctrl_reg[CTRL_SRC_BIT];
    // R6 edge select
    wire         edge_rise = ctrl_reg[CTRL_EDGE_BIT];
    // R7 prescale field
    wire [PS_W-1:0] ps_code = ctrl_reg[CTRL_PS_LSB +: PS_W];

    // ============================================================
    // Prescaler and synchroniser

    logic        step;                         // One counting step
    // R12 write clears prescaler
    wire         ps_clear = wr_lo | wr_hi;

    pot_prescaler #(
        .PS_BITS       (PS_BITS)
    ) u_prescaler (
        .clock         (clock),
        .rst_b         (rst_b),
        .clear         (ps_clear),
        .src_int       (src_int),
        .edge_rise     (edge_rise),
        .ps_code       (ps_code),
        .ext_count_pin (ext_count_pin),
        .step          (step)
    );

    // ============================================================
    // Count chain

    // R12 per-byte hold-off
    wire         lo_run   = step & ~blk_lo_reg;
    // R14 carry into high
    wire         lo_carry = lo_run & (&cnt_lo_reg);
    wire         hi_run   = lo_carry & ~blk_hi_reg;
    // R10 wrap at FFFFh
    wire         overflow = hi_run & (&cnt_hi_reg);

    // R1 low byte next value
    // R2 free-running increment
    assign cnt_lo_next = wr_lo  ? wbyte
                       : lo_run ? cnt_lo_reg + 8'h01
                       : cnt_lo_reg;

    // High byte next value; wraps to 00h with the low byte
    assign cnt_hi_next = wr_hi  ? wbyte
                       : hi_run ? cnt_hi_reg + 8'h01
                       : cnt_hi_reg;

    // ============================================================
    // Control and mask next values

    // R15 bit 0 held at zero
    assign ctrl_next = wr_ctrl ? (wbyte & CTRL_WMASK) : ctrl_reg;
    assign mask_next = wr_mask ? (wbyte & STAT_WMASK) : mask_reg;

    // ============================================================
    // Event status

    // Event vector in status layout
    wire  [7:0]  ev_set = {7'h00, overflow} << STAT_OVF_BIT;
    // Clear sources: reading status, or taking the vector
    wire  [7:0]  ev_clr = (rd_stat ? STAT_WMASK : 8'h00)
                        | (irq_vector_taken ? ev_set_mask() : 8'h00);

    // Flag position helper for vector acknowledge
    function automatic logic [7:0] ev_set_mask();
        ev_set_mask = 8'h01 << STAT_OVF_BIT;
    endfunction

    // R9 overflow event
    // R11 vector clears flag
    // A set in the same cycle as a clear wins
    assign stat_next = ((stat_reg & ~ev_clr) | ev_set) & STAT_WMASK;

    // R10 masked interrupt
    assign irq_next = |(stat_next & mask_reg);

    // ============================================================
    // Read data mux

    // Unmapped reads answer zero
    always_comb begin
        dat_next = 32'h0000_0000;
        if (hit_ctrl) begin
            dat_next[7:0] = ctrl_reg;
        end else if (hit_lo) begin
            dat_next[7:0] = cnt_lo_reg;
        end else if (hit_hi) begin
            dat_next[7:0] = cnt_hi_reg;
        end else if (hit_stat) begin
            dat_next[7:0] = stat_reg;
        end else if (hit_mask) begin
            dat_next[7:0] = mask_reg;
        end
    end

    // ============================================================
    // Bus answer: one wait state, ack for a single cycle

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= req & ~ack_reg;
        end
    end

    // Read data captured with the ack so it is stable while ack is high
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            dat_reg <= 32'h0000_0000;
        end else if (req & ~ack_reg) begin
            dat_reg <= dat_next;
        end
    end

    // ============================================================
    // Software registers

    // R15 reset to zero
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ctrl_reg <= CTRL_RESET;
            mask_reg <= MASK_RESET;
        end else begin
            ctrl_reg <= ctrl_next;
            mask_reg <= mask_next;
        end
    end

    // Count bytes; power-up value is defined even though software
    // should always load them before relying on the count
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            cnt_lo_reg <= CNT_RESET;
            cnt_hi_reg <= CNT_RESET;
        end else begin
            cnt_lo_reg <= cnt_lo_next;
            cnt_hi_reg <= cnt_hi_next;
        end
    end

    // R12 hold-off for next step
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            blk_lo_reg <= 1'b0;
            blk_hi_reg <= 1'b0;
        end else begin
            blk_lo_reg <= wr_lo;
            blk_hi_reg <= wr_hi;
        end
    end

    // ============================================================
    // Status and interrupt output

    always_ff @(posedge clock) begin
        if (!rst_b) begin
            stat_reg <= STAT_RESET;
            irq_reg  <= 1'b0;
        end else begin
            stat_reg <= stat_next;
            irq_reg  <= irq_next;
        end
    end

    // Edge select for the external interrupt pin lives elsewhere;
    // it is only stored here and handed out
    always_ff @(posedge clock) begin
        if (!rst_b) begin
            ext_int_edge_select_reg <= 1'b0;
        end else begin
            ext_int_edge_select_reg <= ctrl_next[CTRL_EXT_INT_EDGE_SELECT_BIT];
        end
    end

    // ============================================================
    // Outputs, all straight from flops

    assign wb_ack_o            = ack_reg;
    assign wb_dat_o            = dat_reg;
    assign irq                 = irq_reg;
    assign ext_int_edge_select = ext_int_edge_select_reg;

endmodule

// [tb/pot_pin_source.sv]
// External count source: a burst of pin toggles at a chosen pace
`timescale 1ns/1ns
module pot_pin_source (
    input  wire logic        clock,
    input  wire logic        go,
    input  wire logic [10:0] toggles,
    input  wire logic [1:0]  half,
    output logic             ext_count_pin,
    output logic             busy
);
    logic [10:0] left_reg;                              // Toggles still owed
    logic [1:0]  wait_reg;                              // Cycles left at level
    initial begin
        ext_count_pin = 1'b0;
        left_reg = 11'h000;
        wait_reg = 2'h1;
    end
    assign busy = (left_reg != 11'h000);
    // each level held one cycle or more
    always @(posedge clock) begin
        if (go) begin
            left_reg <= toggles;
            wait_reg <= half;
        end else if (busy && wait_reg <= 2'h1) begin
            ext_count_pin <= ~ext_count_pin;
            left_reg <= left_reg - 11'h001;
            wait_reg <= half;
        end else if (busy) begin
            wait_reg <= wait_reg - 2'h1;
        end
    end
endmodule

// [tb/pot_properties.sv]
// Concurrent checks on the timer's bus and edge-select ports, with a cover on irq
`timescale 1ns/1ns
module pot_properties
    import pot_pkg::*;
#(
    parameter int PS_BITS = 8                          // Prescaler length
) (
    input wire logic        clock,
    input wire logic        rst_b,
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [3:0]  wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    input wire logic        ext_count_pin,
    input wire logic        irq_vector_taken,
    input wire logic        irq,
    input wire logic        ext_int_edge_select
);
    // ============================================================
    // Decode helpers
    wire logic [5:0] idx    = wb_adr_i[7:2];           // Register index
    wire logic       req    = wb_cyc_i && wb_stb_i;    // Live request
    wire logic       rd_ack = wb_ack_o && !wb_we_i;    // Read answer
    wire logic       edge_wr = wb_dat_i[7];            // Written edge select
    wire logic       ctl_wr = wb_ack_o && wb_we_i && wb_sel_i[0] && idx == IDX_CTRL;
    wire logic       mapped = idx inside {IDX_CTRL, IDX_CNT_LO, IDX_CNT_HI, IDX_STAT, IDX_MASK};

    default clocking @(posedge clock); endclocking
    default disable iff (!rst_b);

    // ============================================================
    // Bus handshake
    ack_single_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    ack_latency_a: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not answered next cycle");
    ack_needs_req_a: assert property (!req |=> !wb_ack_o)
        else $error("ack without a request");
    read_data_hold_a: assert property (!wb_cyc_i |=> $stable(wb_dat_o))
        else $error("read data moved while idle");
    // ============================================================
    // Register contents
    upper_bits_zero_a: assert property (wb_ack_o |-> wb_dat_o[31:8] == 24'h0)
        else $error("upper read bits not zero");
    ctrl_bit_zero_a: assert property (rd_ack && idx == IDX_CTRL |-> !wb_dat_o[0])
        else $error("control bit 0 read as one");
    unmapped_read_a: assert property (rd_ack && !mapped |-> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    edge_copy_a: assert property (ctl_wr |-> ##2 ext_int_edge_select == $past(edge_wr, 2))
        else $error("edge select output not following control");

    cover property (ctl_wr);
    cover property ($rose(irq));
    cover property (rd_ack && !mapped);
endmodule

bind pot_timer pot_properties #(.PS_BITS(PS_BITS)) pot_properties_inst (
    .clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .ext_count_pin(ext_count_pin),
    .irq_vector_taken(irq_vector_taken), .irq(irq),
    .ext_int_edge_select(ext_int_edge_select));

// [tb/pot_timer_bench.sv]
// Self-checking bench for the prescaled overflow timer
`timescale 1ns/1ns
module pot_timer_bench;
    import pot_pkg::*;
    logic clock, rst_b, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, irq, irq_vector_taken;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic        ext_count_pin, ext_int_edge_select, src_go, src_busy;
    logic [10:0] src_n;                                  // Toggles to send
    logic [1:0]  src_half;                               // Cycles per pin level
    logic [15:0] exp_q[$];                               // Notes: mask, value
    logic [15:0] note;
    int n_fail = 0;
    int n_compared = 0;
    int c;

    pot_timer pot_timer_inst (.clock(clock), .rst_b(rst_b), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
        .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
        .ext_count_pin(ext_count_pin), .irq_vector_taken(irq_vector_taken), .irq(irq),
        .ext_int_edge_select(ext_int_edge_select));
    pot_pin_source pot_pin_source_inst (.clock(clock), .go(src_go), .toggles(src_n),
        .half(src_half), .ext_count_pin(ext_count_pin), .busy(src_busy));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // ============================================================
    // Shared tasks
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected at %0t: got %h want %h", $time, got, exp);
        end
    endtask
    // Interrupt level compare
    task automatic chk_irq(input logic got, input logic exp);
        chk({7'h00, got}, {7'h00, exp});
    endtask
    // One classic cycle; a read leaves a note for the monitor
    task automatic wb(input logic w, input logic [5:0] i, input logic [7:0] d,
                      input logic [7:0] m);
        int t;
        t = 0;
        if (!w) exp_q.push_back({m, d});
        {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, w};
        wb_adr_i <= {i, 2'b00};
        wb_sel_i <= 4'($urandom) | 4'h1;
        wb_dat_i <= {24'($urandom), d};
        do @(posedge clock); while (wb_ack_o !== 1'b1 && ++t < 20);
        if (t >= 20) n_fail++;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
        @(posedge clock);
    endtask
    task automatic load(input logic [7:0] lo, input logic [7:0] hi);
        wb(1'b1, IDX_CNT_LO, lo, 8'h00);
        wb(1'b1, IDX_CNT_HI, hi, 8'h00);
    endtask
    // Burst of pin toggles, then time for the synchroniser to settle
    task automatic pins(input logic [10:0] n);
        src_n <= n;
        src_half <= 2'($urandom % 3 + 1);
        src_go <= 1'b1;
        @(posedge clock);
        src_go <= 1'b0;
        repeat (2) @(posedge clock);
        while (src_busy) @(posedge clock);
        repeat (8) @(posedge clock);
    endtask
    // Irq is a registered level: sample it settled, away from edges
    task automatic irq_is(input logic v);
        repeat (3) @(negedge clock);
        chk_irq(irq, v);
        @(posedge clock);
    endtask
    task automatic stop_test;
        $display("compared %0d, failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Monitor: every read answer is matched against the oldest note
    always @(posedge clock) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            chk(wb_dat_o[7:0] & note[15:8], note[7:0]);
        end
    end

    // Watchdog sized well above the expected run
    initial begin
        #(20 * 60000);
        n_fail++;
        stop_test();
    end

    // ============================================================
    // Main sequence
    initial begin
        {rst_b, wb_cyc_i, wb_stb_i, wb_we_i, irq_vector_taken, src_go} = 6'h00;
        wb_adr_i = 8'h00;
        wb_sel_i = 4'h0;
        wb_dat_i = 32'h0;
        src_n = 11'h000;
        src_half = 2'h1;
        void'($urandom(57));
        repeat (4) @(posedge clock);
        rst_b <= 1'b1;
        @(posedge clock);
        wb(1'b0, IDX_CTRL, 8'h00, 8'hFF);
        wb(1'b0, IDX_CNT_LO, 8'h00, 8'hFF);
        wb(1'b0, IDX_CNT_HI, 8'h00, 8'hFF);
        wb(1'b0, 6'h0F, 8'h00, 8'hFF);
        wb(1'b1, IDX_CTRL, 8'hDF, 8'h00);
        wb(1'b0, IDX_CTRL, 8'hDE, 8'hFF);
        // Three prescaled periods of pin edges give three counts
        for (c = 0; c < 10; c++) begin
            wb(1'b1, IDX_CTRL, {1'b0, 1'($urandom), 1'b0, (c > 8) ? 4'hF : 4'(c), 1'b0}, 8'h00);
            repeat (8) @(posedge clock);
            load(8'h00, 8'h00);
            pins(11'((3 << ((c > 8) ? 8 : c)) * 2));
            wb(1'b0, IDX_CNT_LO, 8'h03, 8'hFF);
        end
        wb(1'b1, IDX_CTRL, 8'h40, 8'h00);
        load(8'hFF, 8'h12);
        pins(11'd2);
        wb(1'b0, IDX_CNT_HI, 8'h13, 8'hFF);
        wb(1'b0, IDX_CNT_LO, 8'h00, 8'hFF);
        wb(1'b1, IDX_MASK, 8'h01, 8'h00);
        load(8'hFF, 8'hFF);
        pins(11'd2);
        irq_is(1'b1);
        wb(1'b0, IDX_CNT_HI, 8'h00, 8'hFF);
        wb(1'b0, IDX_STAT, 8'h01, 8'hFF);
        wb(1'b0, IDX_STAT, 8'h00, 8'hFF);
        irq_is(1'b0);
        // Masked overflow stays quiet until unmasked
        wb(1'b1, IDX_MASK, 8'h00, 8'h00);
        load(8'hFF, 8'hFF);
        pins(11'd2);
        irq_is(1'b0);
        wb(1'b1, IDX_MASK, 8'h01, 8'h00);
        irq_is(1'b1);
        irq_vector_taken <= 1'b1;
        @(posedge clock);
        irq_vector_taken <= 1'b0;
        irq_is(1'b0);
        wb(1'b0, IDX_STAT, 8'h00, 8'hFF);
        // Internal clock runs about one count per cycle
        load(8'h00, 8'h00);
        wb(1'b1, IDX_CTRL, 8'h20, 8'h00);
        repeat (64) @(posedge clock);
        wb(1'b1, IDX_CTRL, 8'h00, 8'h00);
        wb(1'b0, IDX_CNT_LO, 8'h40, 8'hC0);
        stop_test();
    end
endmodule
